// ### pkg/oce_pkg.sv
/*
 Types of the command executor: command codes and state records.
 Assumes the constants header is on the include path.
*/
package oce_pkg;
	typedef enum logic [7:0] {
		OCE_WMODE = 8'h04, OCE_SWRST = 8'h06, OCE_RUN = 8'h0A,
		OCE_STOP = 8'h0B, OCE_MAN = 8'h0C, OCE_AUTO = 8'h0D,
		OCE_AT40 = 8'h0E, OCE_AT100 = 8'h0F, OCE_ATCAN = 8'h10,
		OCE_BANK0 = 8'h1E, OCE_BANK3 = 8'h21, OCE_LSP = 8'h22,
		OCE_RSP = 8'h23, OCE_RSTERR = 8'h2D, OCE_ALM1 = 8'h32,
		OCE_ALMALL = 8'h35, OCE_SAVE1 = 8'h37, OCE_INIT = 8'h38,
		OCE_SAVE2 = 8'h39, OCE_UCFG = 8'h3B
	} oce_cmd_e;
	typedef struct packed {
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic [1:0]  rd_ph;
		logic [7:0]  ar_addr;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [15:0] resp;
		logic        ram_mode;
		logic        alm_en;
		logic [3:0]  onoff;
		logic [3:0]  stune;
		logic        maint;
		logic [3:0]  run;
		logic [3:0]  manual;
		logic [3:0]  at40;
		logic [3:0]  at100;
		logic [7:0]  bank;
		logic [3:0]  rsp;
		logic [11:0] alm_lat;
		logic [3:0]  htr_lat;
		logic [3:0]  st_pend;
		logic [7:0]  boot_cnt;
		logic        nv_commit;
		logic        nv_save_run;
		logic        nv_save_all;
		logic        prm_init;
		logic        swr;
	} oce_state_s;
	typedef struct packed {
		logic [3:0][15:0] mem;
		logic [15:0]      rdata;
	} oce_mem_s;
endpackage

// ### pkg/oce_regs.svh
/*
 Register offsets, codes and timing counts of the command executor.
 Assumes inclusion by bare name from the design files.
*/
`ifndef OCE_REGS_SVH
`define OCE_REGS_SVH
`define OCE_A_CMD   6'h00
`define OCE_A_RESP  6'h01
`define OCE_A_CFG   6'h02
`define OCE_A_CHST  6'h03
`define OCE_A_MV    4'h1
`define OCE_A_LAT   6'h08
`define OCE_CMD_LEN 8'h04
`define OCE_REL_ALL 8'hFF
`define OCE_CLK_MHZ 10
`define OCE_BOOT_NS 10000
`define OCE_BOOT_CYC ((`OCE_BOOT_NS * `OCE_CLK_MHZ + 999) / 1000)
`define OCE_RC_OK   16'h0000
`define OCE_RC_LONG 16'h1001
`define OCE_RC_SHRT 16'h1002
`define OCE_RC_PRM  16'h1100
`define OCE_RC_UNSP 16'h0402
`define OCE_RC_RUN  16'h2201
`define OCE_RC_STOP 16'h2202
`define OCE_RC_MODE 16'h2203
`define OCE_RC_DEV  16'h7011
`define OCE_RC_CFGE 16'h7012
`define OCE_RC_NACC 16'h7013
`define OCE_RC_NVB  16'h7014
`define OCE_RC_BOOT 16'h7015
`define OCE_RC_ELAT 16'h7016
`define OCE_RC_CTLM 16'h7020
`define OCE_RC_SWC  16'h7021
`define OCE_RC_OUTM 16'h7030
`define OCE_RC_MAN  16'h7041
`define OCE_RC_TUNE 16'h7042
`endif

// ### tb/oce_host.sv
/*
 Host model: AXI4-Lite master doing single transfers.
 Assumes bench top oce_top_tb_top takes its timeouts.
*/
`timescale 1ns/1ns
module oce_host (
	input  wire logic        ref_clk,
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// Idle bus from time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
	end
	// Handshakes judged mid-cycle, so the edge never races the slave
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, dn;
		dn = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 64 && !dn; i++) begin
			@(negedge ref_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			dn = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
			// Released payload scrambled, never left stale
			if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
			if (dn) s_axi_bready <= 1'b0;
		end
		if (!dn) oce_top_tb_top.host_timeout();
	endtask
	// Read: address held until taken, rready until data seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, dn;
		dn = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 64 && !dn; i++) begin
			@(negedge ref_clk);
			ta = s_axi_arvalid && s_axi_arready;
			dn = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
			if (ta) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
			if (dn) s_axi_rready <= 1'b0;
		end
		if (!dn) oce_top_tb_top.host_timeout();
	endtask
endmodule

// ### tb/oce_top_tb_top.sv
/*
 Bench of the command executor: startup, gating, then command table,
 latches, storage strobes and soft reset. Assumes oce_host as master.
*/
`timescale 1ns/1ns
module oce_top_tb_top;
	logic        ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, nv_commit;
	logic        nv_save_run, nv_save_all, param_init, soft_reset;
	logic        rt_param;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [3:0]  s_axi_wstrb, gate, run_out, manual_out, rsp_out;
	logic [3:0]  heater_latch;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, bank_out;
	logic [11:0] alarm_latch;
	logic [17:0] ev;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [39:0] rows [31];
	int          n_errors, total_checks, n_commit, n_srst, n_save;
	oce_top u_dut (
		.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .dev_error(gate[3]),
		.cfg_error(gate[2]), .cmd_inhibit(gate[1]), .nvm_busy(gate[0]),
		.porta_wr(ev[1]), .portb_wr(ev[0]), .portb_runtime(rt_param),
		.alarm_evt(ev[17:6]), .htr_evt(ev[5:2]),
		.mv_in(64'h0004_0003_0002_5A5A), .run_out, .manual_out,
		.bank_out, .rsp_out, .alarm_latch, .heater_latch, .nv_commit,
		.nv_save_run, .nv_save_all, .param_init, .soft_reset
	);
	oce_host u_host (
		.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);
	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Strobes stand one cycle, so tally them per edge
	always @(posedge ref_clk) begin
		n_commit += int'(nv_commit === 1'b1);
		n_srst += int'(soft_reset === 1'b1);
		n_save += int'((nv_save_run | nv_save_all | param_init) === 1'b1);
	end
	task automatic chk(input string s, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	// Command word in, response code read back
	task automatic cmd(input logic [23:0] w, input logic [15:0] e);
		u_host.wr(8'h00, {8'h00, w}, r);
		chk("bresp", 32'h0, {30'h0, r});
		u_host.rd(8'h04, d, r);
		chk("resp", {16'h0000, e}, {16'h0000, d[15:0]});
	endtask
	task automatic rdc(input string s, input logic [7:0] a,
		input logic [31:0] m, e);
		u_host.rd(a, d, r);
		chk(s, e, d & m);
	endtask
	// Event inputs pulse one cycle, then settle
	task automatic pls(input logic [17:0] v);
		@(posedge ref_clk);
		ev <= v;
		@(posedge ref_clk);
		ev <= 18'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	task host_timeout;
		n_errors++;
		$display("mismatch bus_wait exp answer got none");
		give_verdict();
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		gate = 4'h0;
		rt_param = 1'b1;
		ev = 18'h0;
		rows = '{40'h04000A0000, 40'h04010E2202, 40'h04000E0000,
			40'h04000F7021, 40'h0400100000, 40'h04000F0000,
			40'h04001E7042, 40'h0400227042, 40'h04000C0000,
			40'h04000C0000, 40'h04000E7041, 40'h04000D0000,
			40'h04000D0000, 40'h04FF102202, 40'h04050A1100,
			40'h0400501100, 40'h04003B0402, 40'h05000A1001,
			40'h03000A1002, 40'h04FF392201, 40'h04FF0B0000,
			40'h04FF390000, 40'h04FF370000, 40'h0400380000,
			40'h0402210000, 40'h04001F0000, 40'h0401200000,
			40'h04FF230000, 40'h04FF220000, 40'h0402230000,
			40'h0400040000};
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		cmd(24'h04000A, 16'h7015);
		rdc("cfg", 8'h08, 32'h1, 32'h1);
		u_host.rd(8'h40, d, r);
		chk("slverr", 32'h2, {30'h0, r});
		u_host.wr(8'h40, 32'h0, r);
		chk("bslverr", 32'h2, {30'h0, r});
		pls(18'h2);
		pls(18'h1);
		chk("commit", 32'h1, n_commit);
		// Fixed parameters commit even in RAM mode
		rt_param <= 1'b0;
		pls(18'h1);
		chk("commit", 32'h2, n_commit);
		rt_param <= 1'b1;
		$display("test startup done");
		repeat (110) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			gate <= 4'(1 << i);
			cmd(24'h04000A, 16'h7014 - 16'(i));
		end
		gate <= 4'h0;
		cmd(24'h04000B, 16'h0000);
		$display("test gating done");
		for (int i = 0; i < 31; i++) begin
			cmd(rows[i][39:16], rows[i][15:0]);
		end
		chk("run", 32'h0, {28'h0, run_out});
		chk("bank", 32'h39, {24'h0, bank_out});
		chk("rsp", 32'h4, {28'h0, rsp_out});
		chk("saves", 32'h3, n_save);
		rdc("chst", 8'h0C, 32'hFFF0, 32'h0);
		rdc("mv0", 8'h10, 32'hFFFF, 32'h5A5A);
		rdc("mode", 8'h08, 32'h1, 32'h0);
		pls(18'h1);
		chk("commit", 32'h3, n_commit);
		cmd(24'h04010C, 16'h0000);
		chk("man", 32'h2, {28'h0, manual_out});
		rdc("mv1", 8'h14, 32'hFFFF, 32'h0002);
		$display("test table done");
		cmd(24'h04030A, 16'h0000);
		chk("run3", 32'h8, {28'h0, run_out});
		pls(18'h8);
		cmd(24'h04010A, 16'h7016);
		chk("htr", 32'h2, {28'h0, heater_latch});
		cmd(24'h04002D, 16'h0000);
		chk("htr", 32'h0, {28'h0, heater_latch});
		u_host.wr(8'h08, 32'h22, r);
		cmd(24'h04030C, 16'h7030);
		cmd(24'h04030E, 16'h7020);
		pls(18'h40);
		chk("alm", 32'h1, {20'h0, alarm_latch});
		pls(18'h180);
		chk("alm", 32'h7, {20'h0, alarm_latch});
		cmd(24'h040033, 16'h0000);
		chk("alm", 32'h5, {20'h0, alarm_latch});
		cmd(24'h04FF35, 16'h0000);
		chk("alm", 32'h0, {20'h0, alarm_latch});
		$display("test latches done");
		u_host.wr(8'h08, 32'h400, r);
		pls(18'h40);
		chk("alm", 32'h0, {20'h0, alarm_latch});
		cmd(24'h04000A, 16'h2203);
		cmd(24'h040006, 16'h0000);
		chk("srst", 32'h1, n_srst);
		chk("run", 32'h0, {28'h0, run_out});
		chk("man", 32'h0, {28'h0, manual_out});
		cmd(24'h04000A, 16'h7015);
		rdc("cfg", 8'h08, 32'h401, 32'h1);
		$display("test reset done");
		give_verdict();
	end
endmodule

// ### verilog/oce_mvmem.sv
/*
 Four-word store of output values saved at auto-to-manual switches.
 Assumes one writer and one reader on the same clock; read data register.
*/
`timescale 1ns/1ns
module oce_mvmem (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        we,
	input  wire logic [1:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [1:0]  raddr,
	output logic      [15:0] rdata
);
	oce_pkg::oce_mem_s s_r;
	oce_pkg::oce_mem_s s_nxt;

	// Read old word first, write after; a same-cycle clash returns the old value
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = s_r.mem[raddr];
		if (we)
			s_nxt.mem[waddr] = wdata;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign rdata = s_r.rdata;
endmodule

// ### verilog/oce_top.sv
/*
 Operation command executor with an AXI4-Lite register slave.
 Assumes status inputs and event pulses come from logic on ref_clk.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "oce_regs.svh"
module oce_top (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        dev_error,
	input  wire logic        cfg_error,
	input  wire logic        cmd_inhibit,
	input  wire logic        nvm_busy,
	input  wire logic        porta_wr,
	input  wire logic        portb_wr,
	input  wire logic        portb_runtime,
	input  wire logic [11:0] alarm_evt,
	input  wire logic [3:0]  htr_evt,
	input  wire logic [63:0] mv_in,
	output logic      [3:0]  run_out,
	output logic      [3:0]  manual_out,
	output logic      [7:0]  bank_out,
	output logic      [3:0]  rsp_out,
	output logic      [11:0] alarm_latch,
	output logic      [3:0]  heater_latch,
	output logic             nv_commit,
	output logic             nv_save_run,
	output logic             nv_save_all,
	output logic             param_init,
	output logic             soft_reset
);
	localparam oce_pkg::oce_state_s RST = '{
		ram_mode: 1'b1,
		boot_cnt: 8'(`OCE_BOOT_CYC),
		default: '0
	};

	oce_pkg::oce_state_s s_r;
	oce_pkg::oce_state_s s_nxt;
	logic        mwe;
	logic [1:0]  mwa;
	logic [15:0] mrd;
	logic        cmd_fire;
	logic [7:0]  c_code;
	logic [7:0]  c_rel;
	logic [7:0]  c_len;
	logic [15:0] glob_rc;

	// Channel selector: one bit, all four, or none for a bad value
	function automatic logic [3:0] ch_mask(input logic [7:0] rel);
		if (rel == `OCE_REL_ALL)
			ch_mask = 4'hF;
		else if (rel < 8'h04)
			ch_mask = 4'(4'h1 << rel[1:0]);
		else
			ch_mask = 4'h0;
	endfunction

	// Power-cycle image that keeps only the bus handshake in flight
	function automatic oce_pkg::oce_state_s soft_rst(
		input oce_pkg::oce_state_s x);
		soft_rst = RST;
		soft_rst.aw_got = x.aw_got;
		soft_rst.aw_addr = x.aw_addr;
		soft_rst.w_got = x.w_got;
		soft_rst.w_data = x.w_data;
		soft_rst.w_strb = x.w_strb;
		soft_rst.bvalid = x.bvalid;
		soft_rst.bresp = x.bresp;
		soft_rst.rd_ph = x.rd_ph;
		soft_rst.ar_addr = x.ar_addr;
		soft_rst.rvalid = x.rvalid;
		soft_rst.rresp = x.rresp;
		soft_rst.rdata = x.rdata;
	endfunction

	oce_mvmem u_mvmem (
		.ref_clk (ref_clk),
		.rst     (rst),
		.we      (mwe),
		.waddr   (mwa),
		.wdata   (mv_in[mwa*16 +: 16]),
		.raddr   (s_r.ar_addr[3:2]),
		.rdata   (mrd)
	);

	// Command decode shared by the executor and its checks
	assign cmd_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid &&
		s_r.aw_addr[7:2] == `OCE_A_CMD && s_r.w_strb[2:0] == 3'h7;
	assign c_code = s_r.w_data[7:0];
	assign c_rel = s_r.w_data[15:8];
	assign c_len = s_r.w_data[23:16];

	// Checks that refuse any command before it executes; only the maintenance check looks at its code
	always_comb begin
		if (c_len > `OCE_CMD_LEN)
			glob_rc = `OCE_RC_LONG;
		else if (c_len < `OCE_CMD_LEN)
			glob_rc = `OCE_RC_SHRT;
		else if (s_r.boot_cnt != 8'h00 || s_r.swr)
			glob_rc = `OCE_RC_BOOT;
		else if (dev_error)
			glob_rc = `OCE_RC_DEV;
		else if (cfg_error)
			glob_rc = `OCE_RC_CFGE;
		else if (cmd_inhibit)
			glob_rc = `OCE_RC_NACC;
		else if (nvm_busy || s_r.st_pend != 4'h0)
			glob_rc = `OCE_RC_NVB;
		else if (s_r.maint && c_code != oce_pkg::OCE_SWRST)
			glob_rc = `OCE_RC_MODE;
		else
			glob_rc = `OCE_RC_OK;
	end

	// Next state: bus slave, executor, latches, saved-value writer
	always_comb begin
		logic [3:0] m;
		logic [3:0] tune;
		logic [15:0] rc;
		logic [5:0] wa;
		logic [5:0] ra;
		m = ch_mask(c_rel);
		tune = s_r.at40 | s_r.at100;
		rc = `OCE_RC_OK;
		wa = s_r.aw_addr[7:2];
		ra = s_r.ar_addr[7:2];
		s_nxt = s_r;
		mwe = 1'b0;
		mwa = 2'h0;
		// Port-A commits except while soft_reset is high; port B only in backup or fixed params
		s_nxt.nv_commit = porta_wr |
			(portb_wr & (~s_r.ram_mode | ~portb_runtime));
		s_nxt.nv_save_run = 1'b0;
		s_nxt.nv_save_all = 1'b0;
		s_nxt.prm_init = 1'b0;
		s_nxt.swr = 1'b0;
		if (s_r.boot_cnt != 8'h00)
			s_nxt.boot_cnt = s_r.boot_cnt - 8'h01;
		// One saved value per cycle, lowest channel first
		if (s_r.st_pend != 4'h0) begin
			mwe = 1'b1;
			for (int i = 3; i >= 0; i--) begin
				if (s_r.st_pend[i])
					mwa = 2'(i);
			end
			s_nxt.st_pend[mwa] = 1'b0;
		end
		// Address and data captured independently
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = 2'h0;
			if (wa == `OCE_A_CFG) begin
				if (s_r.w_strb[0]) begin
					s_nxt.alm_en = s_r.w_data[1];
					s_nxt.onoff = s_r.w_data[5:2];
				end
				if (s_r.w_strb[1]) begin
					s_nxt.stune = s_r.w_data[9:6];
					s_nxt.maint = s_r.w_data[10];
				end
			end else if (wa != `OCE_A_CMD && wa != `OCE_A_RESP &&
				wa != `OCE_A_CHST && wa[5:2] != `OCE_A_MV &&
				wa != `OCE_A_LAT)
				s_nxt.bresp = 2'h2;
		end
		// Executor: a whole-channel group is applied or refused as one
		if (cmd_fire && glob_rc != `OCE_RC_OK)
			rc = glob_rc;
		else if (cmd_fire) begin
			unique case (c_code) inside
			oce_pkg::OCE_WMODE: begin
				// Mode change alone never triggers a save
				if (c_rel == 8'h00)
					s_nxt.ram_mode = 1'b0;
				else if (c_rel == 8'h01)
					s_nxt.ram_mode = 1'b1;
				else
					rc = `OCE_RC_PRM;
			end
			oce_pkg::OCE_SWRST: begin
				if (c_rel == 8'h00)
					s_nxt.swr = 1'b1;
				else
					rc = `OCE_RC_PRM;
			end
			oce_pkg::OCE_RUN, oce_pkg::OCE_STOP: begin
				if (m == 4'h0)
					rc = `OCE_RC_PRM;
				else if (c_code == oce_pkg::OCE_STOP)
					s_nxt.run = s_r.run & ~m;
				else if (s_r.htr_lat != 4'h0)
					rc = `OCE_RC_ELAT;
				else
					s_nxt.run = s_r.run | m;
			end
			oce_pkg::OCE_MAN: begin
				if (m == 4'h0)
					rc = `OCE_RC_PRM;
				else if ((m & s_r.onoff) != 4'h0)
					rc = `OCE_RC_OUTM;
				else begin
					s_nxt.st_pend = m & ~s_r.manual;
					s_nxt.manual = s_r.manual | m;
					s_nxt.at40 = s_r.at40 & ~m;
					s_nxt.at100 = s_r.at100 & ~m;
					s_nxt.stune = s_r.stune & ~m;
				end
			end
			oce_pkg::OCE_AUTO: begin
				if (m == 4'h0)
					rc = `OCE_RC_PRM;
				else
					s_nxt.manual = s_r.manual & ~m;
			end
			[oce_pkg::OCE_AT40 : oce_pkg::OCE_ATCAN]: begin
				if (m == 4'h0)
					rc = `OCE_RC_PRM;
				else if ((m & ~s_r.run) != 4'h0)
					rc = `OCE_RC_STOP;
				else if ((m & s_r.manual) != 4'h0)
					rc = `OCE_RC_MAN;
				else if ((m & s_r.onoff) != 4'h0)
					rc = `OCE_RC_CTLM;
				else if (c_code == oce_pkg::OCE_AT40 &&
					(m & s_r.at100) != 4'h0)
					rc = `OCE_RC_SWC;
				else if (c_code == oce_pkg::OCE_AT100 &&
					(m & s_r.at40) != 4'h0)
					rc = `OCE_RC_SWC;
				else if (c_code == oce_pkg::OCE_AT40)
					s_nxt.at40 = s_r.at40 | m;
				else if (c_code == oce_pkg::OCE_AT100)
					s_nxt.at100 = s_r.at100 | m;
				else begin
					s_nxt.at40 = s_r.at40 & ~m;
					s_nxt.at100 = s_r.at100 & ~m;
				end
			end
			[oce_pkg::OCE_BANK0 : oce_pkg::OCE_RSP]: begin
				if (m == 4'h0)
					rc = `OCE_RC_PRM;
				else if ((m & tune) != 4'h0)
					rc = `OCE_RC_TUNE;
				else if (c_code == oce_pkg::OCE_LSP)
					s_nxt.rsp = s_r.rsp & ~m;
				else if (c_code == oce_pkg::OCE_RSP)
					s_nxt.rsp = s_r.rsp | m;
				else begin
					for (int i = 0; i < 4; i++) begin
						if (m[i])
							s_nxt.bank[2*i +: 2] = 2'(c_code - 8'h1E);
					end
				end
			end
			oce_pkg::OCE_RSTERR: begin
				if (c_rel == 8'h00)
					s_nxt.htr_lat = 4'h0;
				else
					rc = `OCE_RC_PRM;
			end
			[oce_pkg::OCE_ALM1 : oce_pkg::OCE_ALMALL]: begin
				// Without latching enabled this clear has no effect; bits latched earlier stay held
				if (m == 4'h0)
					rc = `OCE_RC_PRM;
				else if (s_r.alm_en) begin
					for (int i = 0; i < 4; i++) begin
						for (int k = 0; k < 3; k++) begin
							if (m[i] && (c_code == 8'h35 ||
								c_code[1:0] == 2'(k + 2)))
								s_nxt.alm_lat[3*i + k] = 1'b0;
						end
					end
				end
			end
			oce_pkg::OCE_SAVE1: begin
				if (c_rel == `OCE_REL_ALL)
					s_nxt.nv_save_run = 1'b1;
				else
					rc = `OCE_RC_PRM;
			end
			oce_pkg::OCE_INIT: begin
				// Defaults in working memory; storage left untouched
				if (c_rel == 8'h00) begin
					s_nxt.prm_init = 1'b1;
					s_nxt.bank = 8'h00;
					s_nxt.rsp = 4'h0;
				end else
					rc = `OCE_RC_PRM;
			end
			oce_pkg::OCE_SAVE2: begin
				if (c_rel != `OCE_REL_ALL)
					rc = `OCE_RC_PRM;
				else if (s_r.run != 4'h0)
					rc = `OCE_RC_RUN;
				else
					s_nxt.nv_save_all = 1'b1;
			end
			oce_pkg::OCE_UCFG:
				rc = `OCE_RC_UNSP;
			default:
				rc = `OCE_RC_PRM;
			endcase
		end
		if (cmd_fire)
			s_nxt.resp = rc;
		// Events set after clears so a same-cycle event survives
		s_nxt.alm_lat = s_nxt.alm_lat | (alarm_evt & {12{s_r.alm_en}});
		s_nxt.htr_lat = s_nxt.htr_lat | htr_evt;
		// Read: phase 1 lets the saved-value store register its word
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rd_ph = 2'h1;
			s_nxt.ar_addr = s_axi_araddr;
		end else if (s_r.rd_ph == 2'h1)
			s_nxt.rd_ph = 2'h2;
		else if (s_r.rd_ph == 2'h2) begin
			s_nxt.rd_ph = 2'h0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = 2'h0;
			s_nxt.rdata = 32'h0000_0000;
			if (ra == `OCE_A_RESP)
				s_nxt.rdata = {14'h0000, s_r.boot_cnt != 8'h00,
					s_r.st_pend != 4'h0, s_r.resp};
			else if (ra == `OCE_A_CFG)
				s_nxt.rdata = {21'h000000, s_r.maint, s_r.stune,
					s_r.onoff, s_r.alm_en, s_r.ram_mode};
			else if (ra == `OCE_A_CHST)
				s_nxt.rdata = {4'h0, s_r.bank, s_r.rsp, s_r.at100,
					s_r.at40, s_r.manual, s_r.run};
			else if (ra[5:2] == `OCE_A_MV)
				s_nxt.rdata = {16'h0000, mrd};
			else if (ra == `OCE_A_LAT)
				s_nxt.rdata = {16'h0000, s_r.htr_lat, s_r.alm_lat};
			else if (ra != `OCE_A_CMD)
				s_nxt.rresp = 2'h2;
		end
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		// Software reset lands one cycle after its pulse
		if (s_r.swr)
			s_nxt = soft_rst(s_nxt);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			s_r <= RST;
		else
			s_r <= s_nxt;
	end

	// Ready terms are combinational; everything else is registered
	assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
	assign s_axi_arready = s_r.rd_ph == 2'h0 && !s_r.rvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rdata   = s_r.rdata;
	assign run_out       = s_r.run;
	assign manual_out    = s_r.manual;
	assign bank_out      = s_r.bank;
	assign rsp_out       = s_r.rsp;
	assign alarm_latch   = s_r.alm_lat;
	assign heater_latch  = s_r.htr_lat;
	assign nv_commit     = s_r.nv_commit;
	assign nv_save_run   = s_r.nv_save_run;
	assign nv_save_all   = s_r.nv_save_all;
	assign param_init    = s_r.prm_init;
	assign soft_reset    = s_r.swr;

	// Checks on the executor and its side effects
	sequence s_man_ch0;
		cmd_fire && glob_rc == `OCE_RC_OK && c_code == 8'h0C &&
			c_rel == 8'h00 && !s_r.manual[0] && !s_r.onoff[0];
	endsequence
	sequence s_store_ch0;
		##[1:4] (mwe && mwa == 2'h0);
	endsequence

	property p_len;
		@(posedge ref_clk) disable iff (rst)
		cmd_fire && c_len > `OCE_CMD_LEN |=> s_r.resp == `OCE_RC_LONG;
	endproperty
	a_len: assert property (p_len) else $error("over-length code");

	property p_short;
		@(posedge ref_clk) disable iff (rst)
		cmd_fire && c_len < `OCE_CMD_LEN |=> s_r.resp == `OCE_RC_SHRT;
	endproperty
	a_short: assert property (p_short) else $error("short code");

	property p_boot;
		@(posedge ref_clk) disable iff (rst)
		soft_reset |=> s_r.boot_cnt == 8'(`OCE_BOOT_CYC) && run_out == 4'h0
			&& s_r.ram_mode;
	endproperty
	a_boot: assert property (p_boot) else $error("soft reset image");

	property p_porta;
		@(posedge ref_clk) disable iff (rst)
		porta_wr |=> nv_commit;
	endproperty
	a_porta: assert property (p_porta) else $error("port A no commit");

	property p_nosave;
		@(posedge ref_clk) disable iff (rst)
		$fell(s_r.ram_mode) |-> !nv_save_run && !nv_save_all;
	endproperty
	a_nosave: assert property (p_nosave) else $error("mode saved");

	property p_store;
		@(posedge ref_clk) disable iff (rst)
		s_man_ch0 |-> s_store_ch0;
	endproperty
	a_store: assert property (p_store) else $error("value not stored");

	property p_abort;
		@(posedge ref_clk) disable iff (rst)
		s_man_ch0 |=> manual_out[0] && !s_r.at40[0] && !s_r.at100[0];
	endproperty
	a_abort: assert property (p_abort) else $error("tune not aborted");

	property p_at_stop;
		@(posedge ref_clk) disable iff (rst)
		cmd_fire && glob_rc == `OCE_RC_OK &&
			c_code inside {[8'h0E:8'h10]} &&
			c_rel == `OCE_REL_ALL && run_out != 4'hF
			|=> s_r.resp == `OCE_RC_STOP && $stable(s_r.at40);
	endproperty
	a_at_stop: assert property (p_at_stop) else $error("AT while stop");

	property p_save2;
		@(posedge ref_clk) disable iff (rst)
		cmd_fire && glob_rc == `OCE_RC_OK && c_code == 8'h39 &&
			c_rel == `OCE_REL_ALL && run_out != 4'h0
			|=> s_r.resp == `OCE_RC_RUN && !nv_save_all;
	endproperty
	a_save2: assert property (p_save2) else $error("save2 running");

	property p_alm;
		@(posedge ref_clk) disable iff (rst)
		alarm_evt[0] && s_r.alm_en |=> alarm_latch[0];
	endproperty
	a_alm: assert property (p_alm) else $error("alarm event lost");
endmodule
